// ### hdl/dma_buf_defs.svh
`ifndef DMA_BUF_DEFS_SVH
`define DMA_BUF_DEFS_SVH
`define CH0_WR_INDEX_HI_OFS 16'hffbb
`define CH0_WR_INDEX_LO_OFS 16'hffbc
`define CH1_WR_INDEX_HI_OFS 16'hffb7
`define CH1_WR_INDEX_LO_OFS 16'hffb8
`define CH0_RD_INDEX_HI_OFS 16'hffb9
`define CH0_RD_INDEX_LO_OFS 16'hffba
`define CH1_RD_INDEX_HI_OFS 16'hffb5
`define CH1_RD_INDEX_LO_OFS 16'hffb6
`define CH0_FILL_LO_OFS 16'hffeb
`define CH0_FILL_HI_OFS 16'hffec
`define CH1_FILL_LO_OFS 16'hfff3
`define CH1_FILL_HI_OFS 16'hfff4
`define BULK_TOTAL_HI_OFS 16'hfff1
`define BULK_TOTAL_LO_OFS 16'hfff2
`define CH0_CTL_OFS 16'hffe8
`define CH1_CTL_OFS 16'hffee
`define CTL_ENABLE_BIT 7
`define CTL_HSK_BIT 6
`define CTL_RESET 8'h00
`define BULK_TOTAL_RESET 16'h0000
`define FILL_RESET 16'h0000
`define INDEX_RESET 11'h000
`endif

// ### hdl/dma_buf_pkg.sv
`default_nettype none
package dma_buf_pkg;
  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [10:0] index_t;
  typedef logic [15:0] count_t;
  typedef enum logic {CH_IDLE, CH_RUN} ch_state_t;
endpackage
`default_nettype wire

// ### hdl/chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic sof;
  logic pkt_done;
  logic byte_taken;
  logic [15:0] fill_in;
  logic ctl_we;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_q;
  logic [15:0] fill_q;
  logic [10:0] rd_index;
  logic irq;
  logic hs_done;
  logic en;
  modport track (input sof, pkt_done, byte_taken, fill_in, ctl_we, ctl_wdata,
                 output ctl_q, fill_q, rd_index, irq, hs_done, en);
  modport top (output sof, pkt_done, byte_taken, fill_in, ctl_we, ctl_wdata,
               input ctl_q, fill_q, rd_index, irq, hs_done, en);
endinterface
`default_nettype wire

// ### hdl/dma_chan_track.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_buf_defs.svh"
module dma_chan_track (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // channel link to the register bank
  chan_if.track ch
);
  import dma_buf_pkg::*;

  ch_state_t state_r, state_nxt;
  logic hsk_r, hsk_nxt;
  logic [3:0] ep_r, ep_nxt;
  logic [15:0] fill_r, fill_nxt;
  logic [10:0] rd_r, rd_nxt;
  logic irq_r, irq_nxt;
  logic hs_r, hs_nxt;
  logic done_now;

  always_comb
  begin
    state_nxt = state_r;
    hsk_nxt = hsk_r;
    ep_nxt = ep_r;
    fill_nxt = fill_r;
    rd_nxt = rd_r;
    done_now = (state_r == CH_RUN) && hsk_r && ch.pkt_done;
    irq_nxt = done_now;
    hs_nxt = done_now;
    if (ch.sof)
    begin
      fill_nxt = ch.fill_in;
    end
    if ((state_r == CH_RUN) && ch.byte_taken)
    begin
      rd_nxt = rd_r + 11'h001;
    end
    case (state_r)
      CH_IDLE: state_nxt = CH_IDLE;
      CH_RUN:
      begin
        if (done_now)
        begin
          state_nxt = CH_IDLE;
        end
      end
      default: state_nxt = CH_IDLE;
    endcase
    // a software write in the same cycle wins so a re-arm is never lost
    if (ch.ctl_we)
    begin
      state_nxt = ch.ctl_wdata[`CTL_ENABLE_BIT] ? CH_RUN : CH_IDLE;
      hsk_nxt = ch.ctl_wdata[`CTL_HSK_BIT];
      ep_nxt = ch.ctl_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= CH_IDLE;
      hsk_r <= 1'b0;
      ep_r <= 4'h0;
      fill_r <= `FILL_RESET;
      rd_r <= `INDEX_RESET;
      irq_r <= 1'b0;
      hs_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hsk_r <= hsk_nxt;
      ep_r <= ep_nxt;
      fill_r <= fill_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
      hs_r <= hs_nxt;
    end
  end

  assign ch.en = (state_r == CH_RUN);
  assign ch.ctl_q = {ch.en, hsk_r, 2'b00, ep_r};
  assign ch.fill_q = fill_r;
  assign ch.rd_index = rd_r;
  assign ch.irq = irq_r;
  assign ch.hs_done = hs_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_hsk_done;
    ch.en && hsk_r && ch.pkt_done && !ch.ctl_we;
  endsequence
  sequence s_self_off;
    !ch.en && ch.irq;
  endsequence
  property p_hsk_self_disable;
    s_hsk_done |=> s_self_off ##1 !ch.irq;
  endproperty
  a_hsk_self_disable: assert property (p_hsk_self_disable) else $error("handshake packet did not stop channel");

  property p_fill_steady;
    !ch.sof |=> $stable(ch.fill_q);
  endproperty
  a_fill_steady: assert property (p_fill_steady) else $error("fill count moved inside a frame");

  property p_fill_capture;
    ch.sof |=> ch.fill_q == $past(ch.fill_in);
  endproperty
  a_fill_capture: assert property (p_fill_capture) else $error("fill count not captured at frame start");

  property p_rd_step;
    ch.en && ch.byte_taken |=> ch.rd_index == $past(ch.rd_index) + 11'h001;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read index did not advance");
endmodule // dma_chan_track
`default_nettype wire

// ### hdl/dma_buffer_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_buf_defs.svh"
module dma_buffer_status_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // microcontroller register port
  input wire dma_buf_pkg::addr_t mcu_addr_i,
  input wire logic mcu_wr_i,
  input wire logic mcu_rd_i,
  input wire dma_buf_pkg::byte_t mcu_wdata_i,
  output dma_buf_pkg::byte_t mcu_rdata_o,
  // buffer manager and frame timing
  input wire logic sof_i,
  input wire logic [1:0][10:0] manager_write_index_i,
  input wire logic [1:0][15:0] iso_fill_i,
  // dma engine
  input wire logic [1:0] pkt_done_i,
  input wire logic [1:0] byte_taken_i,
  output logic [1:0] channel_enable_o,
  output logic [1:0] packet_handshake_enable_o,
  output logic [1:0] packet_irq_o,
  output dma_buf_pkg::count_t bulk_packets_remaining_o
);
  import dma_buf_pkg::*;

  localparam addr_t CTL_ADDR [2] = '{`CH0_CTL_OFS, `CH1_CTL_OFS};

  chan_if ch_if [2] ();
  byte_t rdata_r, rdata_nxt;
  count_t bulk_r, bulk_nxt;
  logic [1:0] dec_req;
  logic [1:0] dec_amt;
  logic [1:0][7:0] ctl_q;
  logic [1:0][15:0] fill_q;
  logic [1:0][10:0] rd_q;
  logic [1:0][10:0] wr_q;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      assign ch_if[g].sof = sof_i;
      assign ch_if[g].pkt_done = pkt_done_i[g];
      assign ch_if[g].byte_taken = byte_taken_i[g];
      assign ch_if[g].fill_in = iso_fill_i[g];
      assign ch_if[g].ctl_we = mcu_wr_i && (mcu_addr_i == CTL_ADDR[g]);
      assign ch_if[g].ctl_wdata = mcu_wdata_i;
      assign ctl_q[g] = ch_if[g].ctl_q;
      assign fill_q[g] = ch_if[g].fill_q;
      assign rd_q[g] = ch_if[g].rd_index;
      assign dec_req[g] = ch_if[g].hs_done;
      assign channel_enable_o[g] = ch_if[g].en;
      assign packet_handshake_enable_o[g] = ch_if[g].ctl_q[`CTL_HSK_BIT];
      assign packet_irq_o[g] = ch_if[g].irq;
      assign wr_q[g] = manager_write_index_i[g];
      dma_chan_track u_track (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ch(ch_if[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // both channels may finish a packet in one cycle
  assign dec_amt = {1'b0, dec_req[0]} + {1'b0, dec_req[1]};

  always_comb
  begin
    bulk_nxt = bulk_r;
    if (bulk_r >= {14'h0000, dec_amt})
    begin
      bulk_nxt = bulk_r - {14'h0000, dec_amt};
    end
    else
    begin
      bulk_nxt = 16'h0000;
    end
    // a software byte write replaces that byte, the other keeps the decrement
    if (mcu_wr_i && (mcu_addr_i == `BULK_TOTAL_LO_OFS))
    begin
      bulk_nxt[7:0] = mcu_wdata_i;
    end
    if (mcu_wr_i && (mcu_addr_i == `BULK_TOTAL_HI_OFS))
    begin
      bulk_nxt[15:8] = mcu_wdata_i;
    end
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (mcu_rd_i)
    begin
      case (mcu_addr_i)
        `CH0_FILL_LO_OFS: rdata_nxt = fill_q[0][7:0];
        `CH0_FILL_HI_OFS: rdata_nxt = fill_q[0][15:8];
        `CH1_FILL_LO_OFS: rdata_nxt = fill_q[1][7:0];
        `CH1_FILL_HI_OFS: rdata_nxt = fill_q[1][15:8];
        `BULK_TOTAL_LO_OFS: rdata_nxt = bulk_r[7:0];
        `BULK_TOTAL_HI_OFS: rdata_nxt = bulk_r[15:8];
        `CH0_WR_INDEX_LO_OFS: rdata_nxt = wr_q[0][7:0];
        `CH0_WR_INDEX_HI_OFS: rdata_nxt = {5'h00, wr_q[0][10:8]};
        `CH1_WR_INDEX_LO_OFS: rdata_nxt = wr_q[1][7:0];
        `CH1_WR_INDEX_HI_OFS: rdata_nxt = {5'h00, wr_q[1][10:8]};
        `CH0_RD_INDEX_LO_OFS: rdata_nxt = rd_q[0][7:0];
        `CH0_RD_INDEX_HI_OFS: rdata_nxt = {5'h00, rd_q[0][10:8]};
        `CH1_RD_INDEX_LO_OFS: rdata_nxt = rd_q[1][7:0];
        `CH1_RD_INDEX_HI_OFS: rdata_nxt = {5'h00, rd_q[1][10:8]};
        `CH0_CTL_OFS: rdata_nxt = ctl_q[0];
        `CH1_CTL_OFS: rdata_nxt = ctl_q[1];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bulk_r <= `BULK_TOTAL_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      bulk_r <= bulk_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign mcu_rdata_o = rdata_r;
  assign bulk_packets_remaining_o = bulk_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_bulk_write_lo;
    mcu_wr_i && mcu_addr_i == `BULK_TOTAL_LO_OFS |=> bulk_r[7:0] == $past(mcu_wdata_i);
  endproperty
  a_bulk_write_lo: assert property (p_bulk_write_lo) else $error("bulk count low byte not written");

  property p_bulk_dec;
    dec_req == 2'b01 && bulk_r != 16'h0000 && !mcu_wr_i |=> bulk_r == $past(bulk_r) - 16'h0001;
  endproperty
  a_bulk_dec: assert property (p_bulk_dec) else $error("bulk count did not drop by one");

  property p_bulk_read;
    mcu_rd_i && mcu_addr_i == `BULK_TOTAL_HI_OFS |=> mcu_rdata_o == $past(bulk_r[15:8]);
  endproperty
  a_bulk_read: assert property (p_bulk_read) else $error("bulk count read wrong");

  property p_wr_index_hi;
    mcu_rd_i && mcu_addr_i == `CH1_WR_INDEX_HI_OFS |=> mcu_rdata_o == {5'h00, $past(wr_q[1][10:8])};
  endproperty
  a_wr_index_hi: assert property (p_wr_index_hi) else $error("write index high byte wrong");

  property p_fill_read;
    mcu_rd_i && mcu_addr_i == `CH0_FILL_LO_OFS |=> mcu_rdata_o == $past(fill_q[0][7:0]);
  endproperty
  a_fill_read: assert property (p_fill_read) else $error("fill count low byte read wrong");

  property p_fill_read_hi;
    mcu_rd_i && mcu_addr_i == `CH1_FILL_HI_OFS |=> mcu_rdata_o == $past(fill_q[1][15:8]);
  endproperty
  a_fill_read_hi: assert property (p_fill_read_hi) else $error("fill count high byte read wrong");

  property p_wr_index_lo;
    mcu_rd_i && mcu_addr_i == `CH0_WR_INDEX_LO_OFS |=> mcu_rdata_o == $past(wr_q[0][7:0]);
  endproperty
  a_wr_index_lo: assert property (p_wr_index_lo) else $error("write index low byte wrong");

  property p_rd_index_hi;
    mcu_rd_i && mcu_addr_i == `CH0_RD_INDEX_HI_OFS |=> mcu_rdata_o == {5'h00, $past(rd_q[0][10:8])};
  endproperty
  a_rd_index_hi: assert property (p_rd_index_hi) else $error("read index high byte wrong");

  property p_rd_index_lo;
    mcu_rd_i && mcu_addr_i == `CH1_RD_INDEX_LO_OFS |=> mcu_rdata_o == $past(rd_q[1][7:0]);
  endproperty
  a_rd_index_lo: assert property (p_rd_index_lo) else $error("read index low byte wrong");

  ////////////////////////////////////////////////////////////////////////////
  property p_bulk_write_hi;
    mcu_wr_i && mcu_addr_i == `BULK_TOTAL_HI_OFS |=> bulk_r[15:8] == $past(mcu_wdata_i);
  endproperty
  a_bulk_write_hi: assert property (p_bulk_write_hi) else $error("bulk count high byte not written");

  // a read must never disturb the count the engine works from
  property p_bulk_read_quiet;
    mcu_rd_i && dec_req == 2'b00 && !mcu_wr_i |=> $stable(bulk_r);
  endproperty
  a_bulk_read_quiet: assert property (p_bulk_read_quiet) else $error("bulk count moved on a read");

  property p_bulk_dec_both;
    dec_req == 2'b11 && bulk_r >= 16'h0002 && !mcu_wr_i |=> bulk_r == $past(bulk_r) - 16'h0002;
  endproperty
  a_bulk_dec_both: assert property (p_bulk_dec_both) else $error("bulk count did not drop by two");

  // saturate rather than wrap, else one extra packet would look like 64K pending
  property p_bulk_floor;
    dec_req != 2'b00 && bulk_r <= 16'h0001 && !mcu_wr_i |=> bulk_r == 16'h0000;
  endproperty
  a_bulk_floor: assert property (p_bulk_floor) else $error("bulk count wrapped below zero");

  sequence s_ch0_packet_end;
    channel_enable_o[0] && packet_handshake_enable_o[0] && pkt_done_i[0] && !pkt_done_i[1] && !mcu_wr_i;
  endsequence
  sequence s_quiet_nonzero;
    !mcu_wr_i && bulk_r != 16'h0000;
  endsequence

  property p_ch0_packet_debit;
    s_ch0_packet_end ##1 s_quiet_nonzero |=> bulk_r == $past(bulk_r) - 16'h0001;
  endproperty
  a_ch0_packet_debit: assert property (p_ch0_packet_debit) else $error("handshake packet not debited");

  property p_ch0_irq_pulse;
    s_ch0_packet_end |=> packet_irq_o[0] && !channel_enable_o[0] ##1 !packet_irq_o[0];
  endproperty
  a_ch0_irq_pulse: assert property (p_ch0_irq_pulse) else $error("handshake interrupt pulse wrong");
endmodule // dma_buffer_status_regs
`default_nettype wire

// ### bench/dma_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module dma_engine_model (
  // clock
  input wire logic sys_clk_i,
  // frame timing and buffer manager
  output logic sof_o,
  output logic [1:0][15:0] iso_fill_o,
  output logic [1:0][10:0] write_index_o,
  // dma engine events
  output logic [1:0] pkt_done_o,
  output logic [1:0] byte_taken_o
);
  initial
  begin
    sof_o = 1'b0;
    iso_fill_o = '0;
    write_index_o = '0;
    pkt_done_o = 2'b00;
    byte_taken_o = 2'b00;
  end

  // fill may drift mid-frame; sof only when asked
  task automatic load_fill(input logic [15:0] f0, input logic [15:0] f1, input logic frame);
    @(posedge sys_clk_i);
    iso_fill_o <= {f1, f0};
    sof_o <= frame;
    @(posedge sys_clk_i);
    sof_o <= 1'b0;
  endtask

  task automatic set_index(input logic [10:0] w0, input logic [10:0] w1);
    @(posedge sys_clk_i);
    write_index_o <= {w1, w0};
  endtask

  task automatic take_bytes(input int ch, input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      byte_taken_o[ch] <= 1'b1;
      @(posedge sys_clk_i);
      byte_taken_o[ch] <= 1'b0;
    end
  endtask

  // one bit per channel, so both may finish in the same cycle
  task automatic finish_packet(input logic [1:0] chans);
    @(posedge sys_clk_i);
    pkt_done_o <= chans;
    @(posedge sys_clk_i);
    pkt_done_o <= 2'b00;
  endtask
endmodule // dma_engine_model
`default_nettype wire

// ### bench/dma_buffer_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module dma_buffer_status_regs_test;
  import dma_buf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  addr_t addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  byte_t wdata = 8'h00;
  byte_t rdata;
  wire logic sof;
  wire logic [1:0][15:0] fill;
  wire logic [1:0][10:0] widx;
  wire logic [1:0] pkt_done;
  wire logic [1:0] taken;
  logic [1:0] channel_enable_o;
  logic [1:0] packet_handshake_enable_o;
  logic [1:0] packet_irq_o;
  count_t bulk_packets_remaining_o;
  int miscompares = 0;
  int tests_run = 0;
  addr_t zero_map [14] = '{16'hffeb, 16'hffec, 16'hfff3, 16'hfff4, 16'hfff1, 16'hfff2, 16'hffbc,
                           16'hffbb, 16'hffb8, 16'hffb7, 16'hffba, 16'hffb9, 16'hffb6, 16'hffb5};

  always #5 sys_clk_i = ~sys_clk_i;

  dma_buffer_status_regs u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mcu_addr_i(addr), .mcu_wr_i(wr), .mcu_rd_i(rd),
    .mcu_wdata_i(wdata), .mcu_rdata_o(rdata), .sof_i(sof), .manager_write_index_i(widx),
    .iso_fill_i(fill), .pkt_done_i(pkt_done), .byte_taken_i(taken),
    .channel_enable_o(channel_enable_o), .packet_handshake_enable_o(packet_handshake_enable_o),
    .packet_irq_o(packet_irq_o), .bulk_packets_remaining_o(bulk_packets_remaining_o)
  );

  dma_engine_model u_eng (
    .sys_clk_i(sys_clk_i), .sof_o(sof), .iso_fill_o(fill), .write_index_o(widx),
    .pkt_done_o(pkt_done), .byte_taken_o(taken)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input addr_t a, input byte_t d);
    @(posedge sys_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  // data lands at the taking edge; sample once it settles
  task automatic check_read(input addr_t a, input byte_t exp);
    @(posedge sys_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    check(16'(rdata), 16'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20us;
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (zero_map[i]) check_read(zero_map[i], 8'h00);
    $display("reset values done");
    reg_write(16'hfff1, 8'h01);
    reg_write(16'hfff2, 8'h02);
    reg_write(16'hffeb, 8'h55);
    check_read(16'hfff1, 8'h01);
    check_read(16'hfff2, 8'h02);
    check_read(16'hffeb, 8'h00);
    check_read(16'hff00, 8'h00);
    $display("access kinds done");
    u_eng.load_fill(16'h1234, 16'habcd, 1'b1);
    check_read(16'hffeb, 8'h34);
    check_read(16'hffec, 8'h12);
    check_read(16'hfff3, 8'hcd);
    u_eng.load_fill(16'hffff, 16'h0000, 1'b0);
    check_read(16'hffeb, 8'h34);
    check_read(16'hfff4, 8'hab);
    u_eng.load_fill(16'hffff, 16'h0000, 1'b1);
    check_read(16'hffec, 8'hff);
    $display("frame capture done");
    u_eng.set_index(11'h5a5, 11'h7ff);
    check_read(16'hffbc, 8'ha5);
    check_read(16'hffbb, 8'h05);
    check_read(16'hffb8, 8'hff);
    check_read(16'hffb7, 8'h07);
    $display("write index done");
    // count was programmed before this enable
    reg_write(16'hffe8, 8'hc1);
    #1;
    check(16'(packet_handshake_enable_o), 16'h0001);
    u_eng.take_bytes(0, 3);
    check_read(16'hffba, 8'h03);
    check_read(16'hffb9, 8'h00);
    check_read(16'hfff2, 8'h02);
    check(16'(channel_enable_o), 16'h0001);
    u_eng.finish_packet(2'b01);
    #1;
    check(16'(packet_irq_o), 16'h0001);
    check(16'(channel_enable_o), 16'h0000);
    // debit lands one cycle after the interrupt
    @(posedge sys_clk_i);
    #1;
    check(16'(packet_irq_o), 16'h0000);
    check(bulk_packets_remaining_o, 16'h0101);
    $display("handshake done");
    // plain mode on the other channel must not consume packets
    reg_write(16'hffee, 8'h82);
    u_eng.finish_packet(2'b10);
    #1;
    check(16'(channel_enable_o), 16'h0002);
    check(bulk_packets_remaining_o, 16'h0101);
    check_read(16'hfff2, 8'h01);
    u_eng.take_bytes(1, 2);
    check_read(16'hffb6, 8'h02);
    check_read(16'hffe8, 8'h41);
    $display("plain mode done");
    // both channels finish together with one packet left: count stops at zero
    reg_write(16'hfff1, 8'h00);
    reg_write(16'hfff2, 8'h01);
    reg_write(16'hffe8, 8'hc1);
    reg_write(16'hffee, 8'hc2);
    u_eng.finish_packet(2'b11);
    #1;
    check(16'(packet_irq_o), 16'h0003);
    @(posedge sys_clk_i);
    #1;
    check(bulk_packets_remaining_o, 16'h0000);
    check(16'(channel_enable_o), 16'h0000);
    $display("saturation done");
    complete_run();
  end
endmodule // dma_buffer_status_regs_test
`default_nettype wire
